//--- logic/gate_counter.sv
// Gated 16-bit counter with companion period timer and AXI4-Lite registers
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/10ps

module gate_counter (
  input  wire logic        I_CLK,          // 20 MHz system clock
  input  wire logic        I_SRST,         // Synchronous reset, active high
  input  wire logic        I_CE,           // Clock enable, freezes all state when low
  input  wire logic [7:0]  I_AWADDR,       // Write address
  input  wire logic        I_AWVALID,      // Write address valid
  output logic             O_AWREADY,      // Write address ready
  input  wire logic [31:0] I_WDATA,        // Write data
  input  wire logic [3:0]  I_WSTRB,        // Write byte strobes
  input  wire logic        I_WVALID,       // Write data valid
  output logic             O_WREADY,       // Write data ready
  output logic [1:0]       O_BRESP,        // Write response
  output logic             O_BVALID,       // Write response valid
  input  wire logic        I_BREADY,       // Write response ready
  input  wire logic [7:0]  I_ARADDR,       // Read address
  input  wire logic        I_ARVALID,      // Read address valid
  output logic             O_ARREADY,      // Read address ready
  output logic [31:0]      O_RDATA,        // Read data
  output logic [1:0]       O_RRESP,        // Read response
  output logic             O_RVALID,       // Read data valid
  input  wire logic        I_RREADY,       // Read data ready
  input  wire logic        I_GATE_PIN,     // External gate pin, asynchronous
  input  wire logic        I_EXT_CLK,      // External count clock pin, asynchronous
  input  wire logic        I_CMP1,         // Comparator one output, asynchronous
  input  wire logic        I_CMP2,         // Comparator two output, asynchronous
  input  wire logic        I_SLEEP,        // Device in sleep, same clock domain
  input  wire logic        I_CAPTURE_EVT,  // Capture event pulse, same clock domain
  output logic [15:0]      O_COUNT,        // Time base for capture/compare units
  output logic             O_CMP_MATCH,    // Compare match pulse
  output logic             O_OVF_IRQ,      // Overflow interrupt request
  output logic             O_GATE_IRQ,     // Gate-event interrupt request
  output logic             O_WAKE          // Wake request from sleep
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [15:0] ctrl_r, count_r, ccp_r, ctrl_nxt;
  logic [7:0]  period_r, comp_r;
  logic [2:0]  ccp_mode_r, pin_s_r, ext_s_r;
  logic [1:0]  c1_s_r, c2_s_r;
  logic [31:0] wmask;
  logic        match_r, ovf_r, gev_r, tog_r, act_d_r, g_d_r, sp_run_r, gval_d_r, c1_tmr_r, c2_tmr_r, spec_r;
  logic        wr_go, rd_go, tick, src, act, g, rise_g, fall_g, gval, cnt_en, inc, cnt_wr, st_wr, arm_hwclr;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: stage 0 only feeds stage 1
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      pin_s_r <= 3'h0;
      ext_s_r <= 3'h0;
      c1_s_r  <= 2'h0;
      c2_s_r  <= 2'h0;
    end else if (I_CE) begin
      pin_s_r <= {pin_s_r[1:0], I_GATE_PIN};
      ext_s_r <= {ext_s_r[1:0], I_EXT_CLK};
      c1_s_r  <= {c1_s_r[0], I_CMP1};
      c2_s_r  <= {c2_s_r[0], I_CMP2};
    end
  end

  // Timer tick: instruction clock each cycle, or rising external edge
  // Sleep stops the instruction clock; only unsynchronised external counting survives
  always_comb begin
    if (ctrl_r[gate_counter_pkg::CTL_EXTCLK]) begin
      tick = ext_s_r[1] & ~ext_s_r[2];
    end else begin
      tick = 1'b1;
    end
    if (I_SLEEP && !(ctrl_r[gate_counter_pkg::CTL_EXTCLK] && ctrl_r[gate_counter_pkg::CTL_ASYNC])) begin
      tick = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Companion 8-bit period timer, fixed to this counter
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      comp_r  <= gate_counter_pkg::COMP_ZERO;
      match_r <= 1'b0;
    end else if (I_CE) begin
      match_r <= 1'b0;
      if (ctrl_r[gate_counter_pkg::CTL_COMP_ON] && !I_SLEEP) begin
        if (comp_r == period_r) begin
          comp_r  <= gate_counter_pkg::COMP_ZERO;
          match_r <= 1'b1;
        end else begin
          comp_r <= comp_r + 8'h01;
        end
      end
    end
  end

  // Comparator copies re-timed to the timer tick when synchronised
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      c1_tmr_r <= 1'b0;
      c2_tmr_r <= 1'b0;
    end else if (I_CE && tick) begin
      c1_tmr_r <= c1_s_r[1];
      c2_tmr_r <= c2_s_r[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate source, polarity, toggle and single-pulse path
  always_comb begin
    unique case (ctrl_r[gate_counter_pkg::CTL_GSS_LO +: 2])
      gate_counter_pkg::GSS_PIN:   src = pin_s_r[1];
      gate_counter_pkg::GSS_MATCH: src = match_r;
      gate_counter_pkg::GSS_CMP1:  src = ctrl_r[gate_counter_pkg::CTL_C1SYNC] ? c1_tmr_r : c1_s_r[1];
      gate_counter_pkg::GSS_CMP2:  src = ctrl_r[gate_counter_pkg::CTL_C2SYNC] ? c2_tmr_r : c2_s_r[1];
    endcase
    act    = ctrl_r[gate_counter_pkg::CTL_GPOL] ? src : ~src;
    g      = ctrl_r[gate_counter_pkg::CTL_GTM] ? tog_r : act;
    rise_g = g & ~g_d_r;
    fall_g = ~g & g_d_r;
    // Starting in the same cycle as the edge avoids losing the first count
    if (ctrl_r[gate_counter_pkg::CTL_GSPM]) begin
      gval = g & (sp_run_r | (ctrl_r[gate_counter_pkg::CTL_ARM] & rise_g));
    end else begin
      gval = g;
    end
    arm_hwclr = ctrl_r[gate_counter_pkg::CTL_GSPM] & sp_run_r & fall_g;
  end

  // Toggle flip-flop and edge history
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      tog_r    <= 1'b0;
      act_d_r  <= 1'b0;
      g_d_r    <= 1'b0;
      gval_d_r <= 1'b0;
    end else if (I_CE) begin
      act_d_r  <= act;
      g_d_r    <= g;
      gval_d_r <= gval;
      if (!ctrl_r[gate_counter_pkg::CTL_GTM]) begin
        tog_r <= 1'b0;
      end else if (act && !act_d_r) begin
        tog_r <= ~tog_r;
      end
    end
  end

  // Single-pulse window: opens on armed rising edge, closes on trailing edge
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      sp_run_r <= 1'b0;
    end else if (I_CE) begin
      if (!ctrl_r[gate_counter_pkg::CTL_GSPM] || !ctrl_r[gate_counter_pkg::CTL_ARM] || arm_hwclr) begin
        sp_run_r <= 1'b0;
      end else if (rise_g) begin
        sp_run_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign wr_go  = I_AWVALID & I_WVALID & ~O_BVALID & ~O_AWREADY;
  assign rd_go  = I_ARVALID & ~O_RVALID & ~O_ARREADY;
  assign wmask  = {{8{I_WSTRB[3]}}, {8{I_WSTRB[2]}}, {8{I_WSTRB[1]}}, {8{I_WSTRB[0]}}};
  assign cnt_wr = wr_go & (I_AWADDR == gate_counter_pkg::OFF_COUNT) & (I_WSTRB[1:0] != 2'h0);
  assign st_wr  = wr_go & (I_AWADDR == gate_counter_pkg::OFF_STATUS);

  // Count enable from on bit and gate; gating off means free running
  assign cnt_en = ctrl_r[gate_counter_pkg::CTL_ON] & (~ctrl_r[gate_counter_pkg::CTL_GE] | gval);
  assign inc    = cnt_en & tick;

  // Control register with hardware-cleared arm flag
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_go && I_AWADDR == gate_counter_pkg::OFF_CTRL) begin
      ctrl_nxt = (ctrl_r & ~wmask[15:0]) | (I_WDATA[15:0] & wmask[15:0]);
    end else if (arm_hwclr) begin
      ctrl_nxt[gate_counter_pkg::CTL_ARM] = 1'b0;
    end
    if (!ctrl_nxt[gate_counter_pkg::CTL_GSPM]) begin
      ctrl_nxt[gate_counter_pkg::CTL_ARM] = 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      ctrl_r   <= gate_counter_pkg::CTRL_RST;
      period_r <= gate_counter_pkg::PERIOD_RST;
    end else if (I_CE) begin
      ctrl_r <= ctrl_nxt;
      if (wr_go && I_AWADDR == gate_counter_pkg::OFF_PERIOD && I_WSTRB[0]) begin
        period_r <= I_WDATA[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter: write beats special-event clear beats increment
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      count_r <= gate_counter_pkg::COUNT_RST;
    end else if (I_CE) begin
      if (cnt_wr) begin
        count_r <= (count_r & ~wmask[15:0]) | (I_WDATA[15:0] & wmask[15:0]);
      end else if (spec_r) begin
        count_r <= gate_counter_pkg::COUNT_RST;
      end else if (inc) begin
        count_r <= count_r + 16'h0001;
      end
      // Otherwise the count holds
    end
  end

  // Sticky flags; a hardware set wins over a same-cycle write-one clear
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      ovf_r <= 1'b0;
      gev_r <= 1'b0;
    end else if (I_CE) begin
      if (inc && !cnt_wr && !spec_r && count_r == gate_counter_pkg::COUNT_MAX) begin
        ovf_r <= 1'b1;
      end else if (st_wr && I_WSTRB[0] && I_WDATA[gate_counter_pkg::ST_OVF]) begin
        ovf_r <= 1'b0;
      end
      if (!gval && gval_d_r) begin
        gev_r <= 1'b1;
      end else if (st_wr && I_WSTRB[0] && I_WDATA[gate_counter_pkg::ST_GEV]) begin
        gev_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture/compare unit using the count as time base
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      ccp_r      <= gate_counter_pkg::COUNT_RST;
      ccp_mode_r <= 3'h0;
      spec_r     <= 1'b0;
    end else if (I_CE) begin
      spec_r <= 1'b0;
      if (wr_go && I_AWADDR == gate_counter_pkg::OFF_CCP) begin
        ccp_r <= (ccp_r & ~wmask[15:0]) | (I_WDATA[15:0] & wmask[15:0]);
        if (I_WSTRB[2]) begin
          ccp_mode_r <= I_WDATA[gate_counter_pkg::CCP_SPEC:gate_counter_pkg::CCP_CAPT];
        end
      end else if (ccp_mode_r[0] && I_CAPTURE_EVT) begin
        ccp_r <= count_r;
      end
      // One clear per match; the cleared count no longer matches a nonzero pair
      if (ccp_mode_r[1] && ccp_mode_r[2] && ccp_r == count_r && !spec_r) begin
        spec_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered block outputs
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_COUNT     <= gate_counter_pkg::COUNT_RST;
      O_CMP_MATCH <= 1'b0;
      O_OVF_IRQ   <= 1'b0;
      O_GATE_IRQ  <= 1'b0;
      O_WAKE      <= 1'b0;
    end else if (I_CE) begin
      O_COUNT     <= count_r;
      O_CMP_MATCH <= ccp_mode_r[1] & (ccp_r == count_r);
      O_OVF_IRQ   <= ovf_r & ctrl_r[gate_counter_pkg::CTL_OVF_IE];
      O_GATE_IRQ  <= gev_r & ctrl_r[gate_counter_pkg::CTL_GEV_IE];
      O_WAKE      <= I_SLEEP & ovf_r & ctrl_r[gate_counter_pkg::CTL_OVF_IE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: both halves taken together, response next cycle
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_AWREADY <= 1'b0;
      O_WREADY  <= 1'b0;
      O_BVALID  <= 1'b0;
      O_BRESP   <= gate_counter_pkg::RESP_OKAY;
    end else if (I_CE) begin
      O_AWREADY <= wr_go;
      O_WREADY  <= wr_go;
      if (wr_go) begin
        O_BVALID <= 1'b1;
        unique case (I_AWADDR)
          gate_counter_pkg::OFF_CTRL, gate_counter_pkg::OFF_STATUS, gate_counter_pkg::OFF_COUNT,
          gate_counter_pkg::OFF_PERIOD, gate_counter_pkg::OFF_CCP: O_BRESP <= gate_counter_pkg::RESP_OKAY;
          default: O_BRESP <= gate_counter_pkg::RESP_SLVERR;
        endcase
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel; gate level is live state
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0000_0000;
      O_RRESP   <= gate_counter_pkg::RESP_OKAY;
    end else if (I_CE) begin
      O_ARREADY <= rd_go;
      if (rd_go) begin
        O_RVALID <= 1'b1;
        O_RRESP  <= gate_counter_pkg::RESP_OKAY;
        O_RDATA  <= 32'h0000_0000;
        unique case (I_ARADDR)
          gate_counter_pkg::OFF_CTRL:   O_RDATA[15:0] <= ctrl_r;
          gate_counter_pkg::OFF_STATUS: O_RDATA[3:0]  <= {tog_r, gev_r, ovf_r, gval};
          gate_counter_pkg::OFF_COUNT:  O_RDATA[15:0] <= count_r;
          gate_counter_pkg::OFF_PERIOD: O_RDATA[15:0] <= {comp_r, period_r};
          gate_counter_pkg::OFF_CCP:    O_RDATA[18:0] <= {ccp_mode_r, ccp_r};
          default:                      O_RRESP       <= gate_counter_pkg::RESP_SLVERR;
        endcase
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end

endmodule

//--- logic/gate_counter_pkg.sv
// Register map, field positions and reset values of the gated counter
package gate_counter_pkg;
  // Register byte offsets (AXI4-Lite, one word each)
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_COUNT  = 8'h08;
  localparam logic [7:0] OFF_PERIOD = 8'h0C;
  localparam logic [7:0] OFF_CCP    = 8'h10;

  // Control register fields
  localparam int CTL_ON      = 0;
  localparam int CTL_GE      = 1;
  localparam int CTL_GPOL    = 2;
  localparam int CTL_GTM     = 3;
  localparam int CTL_GSPM    = 4;
  localparam int CTL_ARM     = 5;
  localparam int CTL_GSS_LO  = 6;
  localparam int CTL_ASYNC   = 8;
  localparam int CTL_EXTCLK  = 9;
  localparam int CTL_C1SYNC  = 10;
  localparam int CTL_C2SYNC  = 11;
  localparam int CTL_OVF_IE  = 12;
  localparam int CTL_GEV_IE  = 13;
  localparam int CTL_COMP_ON = 14;

  // Status register fields
  localparam int ST_GVAL = 0;
  localparam int ST_OVF  = 1;
  localparam int ST_GEV  = 2;
  localparam int ST_TOG  = 3;

  // Capture/compare register fields
  localparam int CCP_CAPT = 16;
  localparam int CCP_CMP  = 17;
  localparam int CCP_SPEC = 18;

  // Gate source select encodings
  localparam logic [1:0] GSS_PIN   = 2'h0;
  localparam logic [1:0] GSS_MATCH = 2'h1;
  localparam logic [1:0] GSS_CMP1  = 2'h2;
  localparam logic [1:0] GSS_CMP2  = 2'h3;

  // Reset values and constants
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
  localparam logic [7:0]  PERIOD_RST = 8'hFF;
  localparam logic [7:0]  COMP_ZERO  = 8'h00;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

//--- test/gate_counter_asserts.sv
// Port-level assertions for the gated counter
`timescale 1ns/10ps
module gate_counter_asserts (
  input wire logic        I_CLK,      // Clock
  input wire logic        I_SRST,     // Sync reset
  input wire logic        I_CE,       // Clock enable
  input wire logic        I_AWVALID,  // Write address valid
  input wire logic        I_WVALID,   // Write data valid
  input wire logic        I_BREADY,   // Response ready
  input wire logic        I_ARVALID,  // Read address valid
  input wire logic        I_RREADY,   // Read ready
  input wire logic        I_SLEEP,    // Sleep
  input wire logic        O_AWREADY,  // Write address ready
  input wire logic        O_WREADY,   // Write data ready
  input wire logic        O_BVALID,   // Response valid
  input wire logic        O_ARREADY,  // Read address ready
  input wire logic        O_RVALID,   // Read valid
  input wire logic [31:0] O_RDATA,    // Read data
  input wire logic [15:0] O_COUNT,    // Count
  input wire logic        O_OVF_IRQ,  // Overflow request
  input wire logic        O_GATE_IRQ, // Gate-event request
  input wire logic        O_WAKE      // Wake request
);
  // One domain, reset masks every check
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SRST);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake steps
  sequence s_wr_take;
    I_CE && I_AWVALID && I_WVALID && !O_BVALID && !O_AWREADY;
  endsequence
  sequence s_wr_ans;
    O_AWREADY && O_WREADY && O_BVALID;
  endsequence
  property p_wr_answer;
    s_wr_take |=> s_wr_ans;
  endproperty
  property p_rd_answer;
    I_CE && I_ARVALID && !O_RVALID && !O_ARREADY |=> O_ARREADY && O_RVALID;
  endproperty
  property p_ready_pulse;
    O_AWREADY && I_CE |-> O_WREADY ##1 !O_AWREADY && !O_WREADY;
  endproperty
  property p_b_hold;
    O_BVALID && !I_BREADY |=> O_BVALID;
  endproperty
  property p_r_hold;
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
  endproperty

  ////////////////////////////////////////////////////////////////////////////////
  // Count only steps by one or clears, unless software wrote it
  property p_count_step;
    $changed(O_COUNT) && !$past(O_AWREADY) && !O_AWREADY
      |-> O_COUNT == $past(O_COUNT) + 16'h0001 || O_COUNT == 16'h0000;
  endproperty
  // Flags fall only after a bus write clears them
  property p_ovf_sticky;
    $fell(O_OVF_IRQ) |-> $past(O_AWREADY) || $past(O_AWREADY, 2);
  endproperty
  property p_gev_sticky;
    $fell(O_GATE_IRQ) |-> $past(O_AWREADY) || $past(O_AWREADY, 2);
  endproperty
  property p_wake;
    O_WAKE && $past(I_CE) |-> O_OVF_IRQ && $past(I_SLEEP);
  endproperty

  a_wr_answer: assert property (p_wr_answer) else $error("write not answered next cycle");
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready pulse malformed");
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  a_r_hold: assert property (p_r_hold) else $error("rvalid or rdata unstable");
  a_count_step: assert property (p_count_step) else $error("count jumped");
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow cleared by itself");
  a_gev_sticky: assert property (p_gev_sticky) else $error("gate event cleared by itself");
  a_wake: assert property (p_wake) else $error("wake without sleep overflow");
endmodule

//--- test/gate_counter_bench.sv
// Self-checking bench for the gated counter
`timescale 1ns/10ps
module gate_counter_bench;
  localparam logic [31:0] on_m  = 32'h0000_0001 << gate_counter_pkg::CTL_ON;
  localparam logic [31:0] ge_m  = 32'h0000_0001 << gate_counter_pkg::CTL_GE;
  localparam logic [31:0] pol_m = 32'h0000_0001 << gate_counter_pkg::CTL_GPOL;
  localparam logic [31:0] tgm_m = 32'h0000_0001 << gate_counter_pkg::CTL_GTM;
  localparam logic [31:0] spm_m = 32'h0000_0001 << gate_counter_pkg::CTL_GSPM;
  localparam logic [31:0] arm_m = 32'h0000_0001 << gate_counter_pkg::CTL_ARM;
  localparam logic [31:0] asy_m = 32'h0000_0001 << gate_counter_pkg::CTL_ASYNC;
  localparam logic [31:0] ext_m = 32'h0000_0001 << gate_counter_pkg::CTL_EXTCLK;
  localparam logic [31:0] sy1_m = 32'h0000_0001 << gate_counter_pkg::CTL_C1SYNC;
  localparam logic [31:0] ovi_m = 32'h0000_0001 << gate_counter_pkg::CTL_OVF_IE;
  localparam logic [31:0] gvi_m = 32'h0000_0001 << gate_counter_pkg::CTL_GEV_IE;
  localparam logic [31:0] cmp_m = 32'h0000_0001 << gate_counter_pkg::CTL_COMP_ON;
  localparam logic [7:0]  r_ctl = gate_counter_pkg::OFF_CTRL;
  localparam logic [7:0]  r_st  = gate_counter_pkg::OFF_STATUS;
  localparam logic [7:0]  r_cnt = gate_counter_pkg::OFF_COUNT;
  localparam logic [7:0]  r_per = gate_counter_pkg::OFF_PERIOD;
  localparam logic [7:0]  r_ccp = gate_counter_pkg::OFF_CCP;
  logic        clk, srst, ce, awv, wv, bready, arv, rready, sleep, capt, g, c1, c2, erun;
  logic        awready, wready, bvalid, arready, rvalid, cmatch, ovf_irq, gate_irq, wake;
  logic [7:0]  awaddr, araddr;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, bres, rres;
  logic [31:0] wdata, rdata, rdat, v;
  logic [15:0] count, top;
  wire         gpin, eclk, cmp1, cmp2;
  int          err_total, checks, cyc, hits;

  gate_counter dut (.I_CLK(clk), .I_SRST(srst), .I_CE(ce), .I_AWADDR(awaddr), .I_AWVALID(awv),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wv), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arv),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_GATE_PIN(gpin), .I_EXT_CLK(eclk), .I_CMP1(cmp1), .I_CMP2(cmp2), .I_SLEEP(sleep),
    .I_CAPTURE_EVT(capt), .O_COUNT(count), .O_CMP_MATCH(cmatch), .O_OVF_IRQ(ovf_irq),
    .O_GATE_IRQ(gate_irq), .O_WAKE(wake));
  gate_source_model src (.i_clk(clk), .i_gate(g), .i_cmp1(c1), .i_cmp2(c2), .i_ext_run(erun),
    .o_gate_pin(gpin), .o_cmp1(cmp1), .o_cmp2(cmp2), .o_ext_clk(eclk));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, compares and bus cycles
  task automatic test_done();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_ok(input logic c, input string m);
    checks++;
    if (c !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Hold both channels until the answering edge, then let one edge pass
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    awaddr <= ad;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    bres = bresp;
    awv <= 1'b0;
    wv <= 1'b0;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] ad);
    araddr <= ad;
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rdat = rdata;
    rres = rresp;
    arv <= 1'b0;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse();
    g <= 1'b1;
    w(4);
    g <= 1'b0;
    w(6);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rd(r_per);
    chk_eq(rdat, 32'h0000_00FF, "period reset");
    rd(8'h14);
    chk_eq({rdat[31:2], rres}, {30'h0000_0000, gate_counter_pkg::RESP_SLVERR}, "unmapped read");
    wr(8'h14, 32'hFFFF_FFFF);
    chk_eq(32'(bres), 32'(gate_counter_pkg::RESP_SLVERR), "unmapped write");
    rd(r_ctl);
    chk_eq(rdat, 32'h0000_0000, "ctrl reset");
  endtask
  // Every polarity against every gate level, then level and event with gating off
  task automatic t_gate();
    for (int p = 0; p < 2; p++) begin
      for (int q = 0; q < 2; q++) begin
        g <= q[0];
        wr(r_ctl, on_m | ge_m | (p[0] ? pol_m : 32'h0000_0000));
        w(6);
        wr(r_cnt, 32'h0000_0000);
        w(12);
        rd(r_cnt);
        chk_ok((rdat[15:0] !== 16'h0000) == (p == q), "gated count");
      end
    end
    wr(r_ctl, on_m | pol_m);
    // The sweep leaves gate events behind
    wr(r_st, 32'h0000_0006);
    rd(r_st);
    chk_eq(rdat[2:0], 3'h1, "level high, gating off");
    g <= 1'b0;
    w(6);
    rd(r_st);
    chk_eq(rdat[2:0], 3'h4, "level low sets event");
    wr(r_st, 32'h0000_0004);
  endtask
  // Only the selected source is active; companion period 3 gives one tick in 4
  task automatic t_sources();
    wr(r_per, 32'h0000_0003);
    for (int s = 0; s < 4; s++) begin
      g <= (s == 0);
      c1 <= (s == 2);
      c2 <= (s == 3);
      wr(r_ctl, on_m | ge_m | pol_m | cmp_m | sy1_m | (32'(s) << 6));
      w(6);
      wr(r_cnt, 32'h0000_0000);
      w(40);
      rd(r_cnt);
      if (s == 1) begin
        chk_ok(rdat >= 9 && rdat <= 12, "chained count");
      end else begin
        chk_ok(rdat >= 40 && rdat <= 46, "source count");
      end
    end
    rd(r_per);
    chk_ok(rdat[15:8] <= 8'h03, "companion wraps at period");
    {c1, c2, g} <= 3'h0;
  endtask
  task automatic t_toggle();
    wr(r_ctl, on_m | ge_m | pol_m | tgm_m);
    pulse();
    rd(r_cnt);
    v = rdat;
    rd(r_st);
    chk_eq(rdat[3], 1'b1, "toggle set");
    rd(r_cnt);
    chk_ok(rdat[15:0] > v[15:0], "counts through low phase");
    pulse();
    rd(r_cnt);
    v = rdat;
    w(10);
    rd(r_cnt);
    chk_eq(rdat, v, "second edge stops");
    pulse();
    wr(r_ctl, on_m | ge_m | pol_m);
    rd(r_st);
    chk_eq(rdat[3], 1'b0, "toggle held clear");
  endtask
  task automatic t_single();
    wr(r_st, 32'h0000_0004);
    wr(r_ctl, on_m | ge_m | pol_m | spm_m | gvi_m);
    wr(r_ctl, on_m | ge_m | pol_m | spm_m | gvi_m | arm_m);
    wr(r_cnt, 32'h0000_0000);
    pulse();
    rd(r_ctl);
    chk_eq(rdat[5], 1'b0, "arm cleared");
    chk_eq(gate_irq, 1'b1, "gate event request");
    rd(r_cnt);
    v = rdat;
    chk_ok(v >= 3 && v <= 6, "one pulse counted");
    pulse();
    rd(r_cnt);
    chk_eq(rdat, v, "blocked until rearmed");
    wr(r_st, 32'h0000_0004);
    chk_eq(gate_irq, 1'b0, "event cleared");
    wr(r_ctl, on_m | ge_m | pol_m | arm_m);
    rd(r_ctl);
    chk_eq(rdat[5], 1'b0, "arm forced off");
    wr(r_ctl, on_m | ge_m | pol_m | tgm_m | spm_m);
    wr(r_ctl, on_m | ge_m | pol_m | tgm_m | spm_m | arm_m);
    wr(r_cnt, 32'h0000_0000);
    pulse();
    w(10);
    pulse();
    rd(r_cnt);
    v = rdat;
    w(10);
    rd(r_cnt);
    chk_ok(rdat == v && v >= 18 && v <= 23, "one full gate cycle");
  endtask
  task automatic t_ovf();
    wr(r_ctl, on_m | ovi_m);
    wr(r_cnt, 32'h0000_FFF0);
    w(30);
    chk_eq(ovf_irq, 1'b1, "wrap sets overflow");
    w(20);
    chk_eq(ovf_irq, 1'b1, "overflow sticky");
    wr(r_st, 32'h0000_0002);
    chk_eq(ovf_irq, 1'b0, "overflow cleared");
    sleep <= 1'b1;
    rd(r_cnt);
    v = rdat;
    w(10);
    rd(r_cnt);
    chk_eq(rdat, v, "sleep stops internal count");
    erun <= 1'b1;
    wr(r_ctl, on_m | ovi_m | asy_m | ext_m);
    wr(r_cnt, 32'h0000_FFFE);
    w(40);
    chk_eq(wake, 1'b1, "overflow wakes");
    {sleep, erun} <= 2'h0;
    wr(r_st, 32'h0000_0002);
  endtask
  task automatic t_ccp();
    wr(r_ctl, 32'h0000_0000);
    wr(r_cnt, 32'h0000_1234);
    wr(r_ccp, 32'h0001_0000);
    capt <= 1'b1;
    @(posedge clk);
    capt <= 1'b0;
    w(2);
    rd(r_ccp);
    chk_eq(rdat[15:0], 16'h1234, "capture copies count");
    wr(r_ccp, 32'h0006_0014);
    // Start below the pair so the match comes soon
    wr(r_cnt, 32'h0000_0000);
    wr(r_ctl, on_m);
    {hits, top} = 0;
    repeat (100) begin
      @(posedge clk);
      hits += (cmatch === 1'b1);
      top = (count > top) ? count : top;
    end
    chk_ok(hits > 0, "compare fired");
    chk_ok(top <= 16'h0016, "special event clears");
    rd(r_st);
    chk_eq(rdat[1], 1'b0, "no overflow on clear");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, hang guard and main sequence
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    {err_total, checks, cyc} = 0;
    {srst, ce, wstrb} = 6'h3F;
    {awv, wv, bready, arv, rready, sleep, capt, g, c1, c2, erun} = 11'h000;
    {awaddr, araddr, wdata} = 48'h0000_0000_0000;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_gate();
    t_sources();
    t_toggle();
    t_single();
    t_ovf();
    t_ccp();
    test_done();
  end
endmodule

bind gate_counter gate_counter_asserts chk (.*);

//--- test/gate_source_model.sv
// Model of the gate pin, comparators and external count clock
`timescale 1ns/10ps
module gate_source_model (
  input  wire logic i_clk,      // System clock
  input  wire logic i_gate,     // Wanted gate pin level
  input  wire logic i_cmp1,     // Wanted comparator one level
  input  wire logic i_cmp2,     // Wanted comparator two level
  input  wire logic i_ext_run,  // External clock runs while high
  output logic      o_gate_pin, // Gate pin
  output logic      o_cmp1,     // Comparator one output
  output logic      o_cmp2,     // Comparator two output
  output logic      o_ext_clk   // External count clock
);
  logic [1:0] div_r; // Slow clock divider, period 4 cycles
  initial begin
    {o_gate_pin, o_cmp1, o_cmp2, o_ext_clk, div_r} = 6'h00;
  end
  // Levels change after the edge; clock stands low when not running
  always @(posedge i_clk) begin
    o_gate_pin <= i_gate;
    o_cmp1 <= i_cmp1;
    o_cmp2 <= i_cmp2;
    div_r <= i_ext_run ? div_r + 2'h1 : 2'h0;
    o_ext_clk <= i_ext_run & div_r[1];
  end
endmodule
